// ===== core/pxr_pkg.sv
// shared constants and carrier types for the proximity sensor read path
package pxr_pkg;

    localparam logic [7:0] DEV_WRITE_BYTE   = 8'h26;
    localparam logic [7:0] DEV_READ_BYTE    = 8'h27;

    localparam logic [7:0] COMMAND_ADDR     = 8'h80;
    localparam logic [7:0] EMIT_CURR_ADDR   = 8'h83;
    localparam logic [7:0] RESULT_HIGH_ADDR = 8'h87;
    localparam logic [7:0] RESULT_LOW_ADDR  = 8'h88;
    localparam logic [7:0] MOD_TIMING_ADDR  = 8'h8F;
    localparam logic [7:0] AMBIENT_RSV_ADDR = 8'h90;

    localparam int         CMD_DEMAND_BIT   = 3;
    localparam int         CMD_READY_BIT    = 5;

    localparam logic [7:0] EMIT_CURR_RESET  = 8'h02;
    localparam logic [7:0] MOD_TIMING_RESET = 8'h01;
    localparam logic [7:0] RESULT_RESET     = 8'h00;
    localparam logic [7:0] POINTER_RESET    = 8'h80;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

    typedef enum logic [5:0] {
        PXR_IDLE = 6'b000001,
        PXR_DEV  = 6'b000010,
        PXR_ACK  = 6'b000100,
        PXR_RX   = 6'b001000,
        PXR_TX   = 6'b010000,
        PXR_MACK = 6'b100000
    } pxr_bus_state_t;

    typedef enum logic [1:0] {
        PXR_STANDBY = 2'b01,
        PXR_MEASURE = 2'b10
    } pxr_meas_state_t;

    // control handed to the analog front end
    typedef struct packed {
        logic       meas_en;
        logic       sink_en;
        logic [7:0] emit_current;
        logic [7:0] mod_timing;
    } pxr_afe_ctrl_t;

    // result returned by the analog front end
    typedef struct packed {
        logic        done;
        logic [15:0] value;
    } pxr_afe_result_t;

endpackage : pxr_pkg

// ===== core/pxr_read_access.sv
// i2c slave register port and measurement control of the proximity sensor
`timescale 1ns/1ps
// How it works
// - no demand means standby, only bus active
// - emitter current sink off during standby
// - address write first, then read returns register
// - stop-start or repeated start both accepted
// - pointer advances by one per read byte
// - answer 26h for write, 27h for read
// - result high at 87h, low at 88h
module pxr_read_access
    import pxr_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_n,
    input  wire pxr_pkg::pxr_afe_result_t afe_result,
    output pxr_pkg::pxr_afe_ctrl_t        afe_ctrl
);
    import pxr_pkg::*;

    pxr_bus_state_t  bus_state;
    pxr_meas_state_t meas_state;
    logic            scl_q;
    logic            sda_q;
    logic [3:0]      bit_cnt;
    logic [7:0]      shreg;
    logic            is_read;
    logic            is_addr;
    logic [7:0]      pointer;
    logic            wr_pulse;
    logic [7:0]      wr_addr;
    logic [7:0]      wr_data;
    logic            demand;
    logic            ready;
    logic [7:0]      emit_current;
    logic [7:0]      mod_timing;
    logic [7:0]      result_high;
    logic [7:0]      result_low;
    logic [7:0]      rd_data;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_cond;
    logic            stop_cond;

    assign scl_rise   = scl_in & ~scl_q;
    assign scl_fall   = ~scl_in & scl_q;
    assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // reserved ambient register and unmapped addresses read as zero
    always_comb begin
        rd_data = 8'h00;
        if (pointer == COMMAND_ADDR) begin
            rd_data[CMD_DEMAND_BIT] = demand;
            rd_data[CMD_READY_BIT]  = ready;
        end else if (pointer == EMIT_CURR_ADDR) begin
            rd_data = emit_current;
        end else if (pointer == RESULT_HIGH_ADDR) begin
            rd_data = result_high;
        end else if (pointer == RESULT_LOW_ADDR) begin
            rd_data = result_low;
        end else if (pointer == MOD_TIMING_ADDR) begin
            rd_data = mod_timing;
        end
    end

    // bus protocol engine; pointer survives stop and repeated start
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_state <= PXR_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            is_read   <= 1'b0;
            is_addr   <= 1'b0;
            pointer   <= POINTER_RESET;
            wr_pulse  <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 8'h00;
            sda_out   <= 1'b0;
            sda_oe_n  <= 1'b1;
        end else begin
            wr_pulse <= 1'b0;
            if (start_cond) begin
                bus_state <= PXR_DEV;
                bit_cnt   <= 4'h0;
                sda_oe_n  <= 1'b1;
            end else if (stop_cond) begin
                bus_state <= PXR_IDLE;
                sda_oe_n  <= 1'b1;
            end else begin
                case (bus_state)
                    PXR_DEV, PXR_RX: begin
                        if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
                            shreg   <= {shreg[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall &&
                                     bit_cnt == BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            if (bus_state == PXR_DEV) begin
                                if (shreg == DEV_WRITE_BYTE ||
                                    shreg == DEV_READ_BYTE) begin
                                    is_read   <= shreg[0];
                                    is_addr   <= ~shreg[0];
                                    sda_oe_n  <= 1'b0;
                                    bus_state <= PXR_ACK;
                                end else begin
                                    bus_state <= PXR_IDLE;
                                end
                            end else begin
                                if (is_addr) begin
                                    pointer <= shreg;
                                end else begin
                                    wr_pulse <= 1'b1;
                                    wr_addr  <= pointer;
                                    wr_data  <= shreg;
                                    pointer  <= pointer + 8'h01;
                                end
                                is_addr   <= 1'b0;
                                sda_oe_n  <= 1'b0;
                                bus_state <= PXR_ACK;
                            end
                        end
                    end
                    PXR_ACK: begin
                        if (scl_fall) begin
                            if (is_read) begin
                                shreg     <= {rd_data[6:0], 1'b0};
                                sda_oe_n  <= rd_data[7];
                                pointer   <= pointer + 8'h01;
                                bit_cnt   <= 4'h1;
                                bus_state <= PXR_TX;
                            end else begin
                                sda_oe_n  <= 1'b1;
                                bus_state <= PXR_RX;
                            end
                        end
                    end
                    PXR_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE) begin
                                sda_oe_n  <= 1'b1;
                                bus_state <= PXR_MACK;
                            end else begin
                                sda_oe_n <= shreg[7];
                                shreg    <= {shreg[6:0], 1'b0};
                                bit_cnt  <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    PXR_MACK: begin
                        // host nack ends the read; only stop or start follows
                        if (scl_rise) begin
                            if (sda_in) begin
                                bus_state <= PXR_IDLE;
                            end else begin
                                bus_state <= PXR_ACK;
                            end
                        end
                    end
                    default: begin
                        bus_state <= PXR_IDLE;
                    end
                endcase
            end
        end
    end

    // software written control registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            emit_current <= EMIT_CURR_RESET;
            mod_timing   <= MOD_TIMING_RESET;
        end else if (wr_pulse) begin
            if (wr_addr == EMIT_CURR_ADDR) begin
                emit_current <= wr_data;
            end else if (wr_addr == MOD_TIMING_ADDR) begin
                mod_timing <= wr_data;
            end
        end
    end

    // measurement sequencing; completion wins over a same-cycle clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meas_state  <= PXR_STANDBY;
            demand      <= 1'b0;
            ready       <= 1'b0;
            result_high <= RESULT_RESET;
            result_low  <= RESULT_RESET;
        end else begin
            if (wr_pulse && wr_addr == COMMAND_ADDR) begin
                ready <= 1'b0;
                if (wr_data[CMD_DEMAND_BIT]) begin
                    demand <= 1'b1;
                end
            end
            case (meas_state)
                PXR_STANDBY: begin
                    if (demand) begin
                        meas_state <= PXR_MEASURE;
                    end
                end
                PXR_MEASURE: begin
                    if (afe_result.done) begin
                        result_high <= afe_result.value[15:8];
                        result_low  <= afe_result.value[7:0];
                        ready       <= 1'b1;
                        demand      <= 1'b0;
                        meas_state  <= PXR_STANDBY;
                    end
                end
                default: begin
                    meas_state <= PXR_STANDBY;
                end
            endcase
        end
    end

    // emitter sink and measurement enables follow the measurement state, and drop in the cycle that done arrives
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            afe_ctrl.meas_en      <= 1'b0;
            afe_ctrl.sink_en      <= 1'b0;
            afe_ctrl.emit_current <= EMIT_CURR_RESET;
            afe_ctrl.mod_timing   <= MOD_TIMING_RESET;
        end else begin
            afe_ctrl.meas_en      <= (meas_state == PXR_MEASURE) &&
                                     !afe_result.done;
            afe_ctrl.sink_en      <= (meas_state == PXR_MEASURE) &&
                                     !afe_result.done;
            afe_ctrl.emit_current <= emit_current;
            afe_ctrl.mod_timing   <= mod_timing;
        end
    end

endmodule : pxr_read_access

// ===== verification/pxr_host.sv
// i2c host controller model on the processor side of the bus
`timescale 1ns/1ps
module pxr_host (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_o
);
    // sda_o high is a release; the pull-up then sets the line
    initial begin
        scl   = 1'b1;
        sda_o = 1'b1;
    end
    // five mclk per step keeps every scl phase above four mclk
    task automatic go(input logic c, input logic d);
        scl   = c;
        sda_o = d;
        repeat (5) @(negedge mclk);
    endtask : go
    task automatic bit_x(input logic b, output logic r);
        go(1'b0, b);
        go(1'b1, b);
        r = sda;
        go(1'b0, b);
    endtask : bit_x
    // entered with scl low this is a repeated start
    task automatic start();
        go(scl, 1'b1);
        go(1'b1, 1'b1);
        go(1'b1, 1'b0);
        go(1'b0, 1'b0);
    endtask : start
    task automatic stop();
        go(1'b0, 1'b0);
        go(1'b1, 1'b0);
        go(1'b1, 1'b1);
    endtask : stop
    // m is the ninth bit: high to release on a write or refuse a read
    task automatic xbyte(input logic [7:0] d, input logic m,
                         output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(m, r);
        ack = !r;
    endtask : xbyte
endmodule : pxr_host

// ===== verification/pxr_read_access_sva.sv
// bus timing and measurement control checks for the read path
`timescale 1ns/1ps
module pxr_read_access_sva
    import pxr_pkg::*;
(
    input wire logic                     mclk,
    input wire logic                     arst_n,
    input wire logic                     scl_in,
    input wire logic                     sda_in,
    input wire logic                     sda_out,
    input wire logic                     sda_oe_n,
    input wire pxr_pkg::pxr_afe_result_t afe_result,
    input wire pxr_pkg::pxr_afe_ctrl_t   afe_ctrl
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    drive_low_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    sink_link_a: assert property (
        afe_ctrl.sink_en == afe_ctrl.meas_en)
        else $error("sink on outside a measurement");
    meas_end_a: assert property (
        afe_result.done |-> ##[1:2] !afe_ctrl.meas_en)
        else $error("no standby after done");
    meas_hold_a: assert property (afe_ctrl.meas_en
        && !afe_result.done && !$past(afe_result.done) |=> afe_ctrl.meas_en)
        else $error("measurement dropped early");
    sink_drop_a: assert property ($fell(afe_ctrl.sink_en) |->
        $past(afe_result.done) || $past(afe_result.done, 2))
        else $error("sink off without done");
    oe_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in &&
        ($past(scl_in) || $past(scl_in, 2) || $past(scl_in, 3)))
        else $error("data drive changed away from scl fall");
    oe_steady_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_n))
        else $error("data drive moved while scl high");
    meas_rise_a: assert property ($rose(afe_ctrl.meas_en) |->
        !scl_in && ($past(scl_in, 4) || $past(scl_in, 5) || $past(scl_in, 6)))
        else $error("measurement started off a write");
endmodule : pxr_read_access_sva
bind pxr_read_access pxr_read_access_sva u_sva (
    .mclk(mclk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .afe_result(afe_result),
    .afe_ctrl(afe_ctrl));

// ===== verification/pxr_read_access_bench.sv
// self-checking bench for the proximity sensor read path
`timescale 1ns/1ps
module pxr_read_access_bench;
    import pxr_pkg::*;
    logic            mclk;
    logic            arst_n;
    logic            scl;
    logic            host_sda;
    logic            sda_out;
    logic            sda_oe_n;
    pxr_afe_result_t afe_result;
    pxr_afe_ctrl_t   afe_ctrl;
    int              fail_count;
    int              samples_checked;
    // pull-up on the data line: either party pulling low wins
    wire logic sda = host_sda & (sda_oe_n | sda_out);
    always #2 mclk = ~mclk;
    pxr_read_access DUT (.mclk(mclk), .arst_n(arst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .afe_result(afe_result), .afe_ctrl(afe_ctrl));
    pxr_host HOST (.mclk(mclk), .sda(sda), .scl(scl), .sda_o(host_sda));
    task automatic check(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic [7:0] q;
        logic       a;
        HOST.xbyte(d, 1'b1, q, a);
        check("ack", 8'(a), 8'(exp_ack));
    endtask : wb
    task automatic rb(input logic last, input logic [7:0] exp);
        logic [7:0] q;
        logic       a;
        HOST.xbyte(8'hFF, last, q, a);
        check("read", q, exp);
    endtask : rb
    task automatic point(input logic [7:0] addr);
        HOST.start();
        wb(8'h26, 1'b1);
        wb(addr, 1'b1);
    endtask : point
    task automatic t_timing();
        check("oe reset", 8'(sda_oe_n), 8'h01);
        check("mod reset", afe_ctrl.mod_timing, 8'h01);
        point(8'h8F);
        wb(8'h01, 1'b1);
        HOST.stop();
        // re-address: the pointer now rests on the reserved place
        point(8'h8F);
        HOST.start();
        wb(8'h27, 1'b1);
        rb(1'b1, 8'h01);
        HOST.stop();
        $display("test timing done");
    endtask : t_timing
    task automatic t_emitter();
        check("cur reset", afe_ctrl.emit_current, 8'h02);
        point(8'h83);
        HOST.stop();
        HOST.start();
        wb(8'h27, 1'b1);
        rb(1'b0, 8'h02);
        rb(1'b1, 8'h00);
        HOST.stop();
        // a new current setting reaches the front end but not the sink
        point(8'h83);
        wb(8'h14, 1'b1);
        HOST.stop();
        check("cur copy", afe_ctrl.emit_current, 8'h14);
        check("sink idle", 8'(afe_ctrl.sink_en), 8'h00);
        $display("test emitter done");
    endtask : t_emitter
    task automatic t_bad_addr();
        HOST.start();
        wb(8'h28, 1'b0);
        wb(8'h26, 1'b0);
        HOST.stop();
        $display("test bad address done");
    endtask : t_bad_addr
    task automatic t_measure();
        check("idle", 8'(afe_ctrl.meas_en), 8'h00);
        point(8'h80);
        wb(8'h08, 1'b1);
        HOST.stop();
        check("meas on", 8'(afe_ctrl.meas_en), 8'h01);
        check("sink on", 8'(afe_ctrl.sink_en), 8'h01);
        afe_result.value = 16'hC35A;
        afe_result.done  = 1'b1;
        @(negedge mclk);
        afe_result.done = 1'b0;
        repeat (3) @(negedge mclk);
        check("sink off", 8'(afe_ctrl.sink_en), 8'h00);
        // a stray done in standby must neither start nor overwrite anything
        afe_result.value = 16'h1234;
        afe_result.done  = 1'b1;
        @(negedge mclk);
        afe_result.done = 1'b0;
        repeat (3) @(negedge mclk);
        check("stray done", 8'(afe_ctrl.meas_en), 8'h00);
        point(8'h87);
        HOST.start();
        wb(8'h27, 1'b1);
        rb(1'b0, 8'hC3);
        rb(1'b1, 8'h5A);
        HOST.stop();
        // demand gone and ready raised once the result has landed
        point(8'h80);
        HOST.start();
        wb(8'h27, 1'b1);
        rb(1'b1, 8'h20);
        HOST.stop();
        $display("test measure done");
    endtask : t_measure
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // the tests need about 4300 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        give_verdict();
    end
    initial begin
        mclk       = 1'b0;
        arst_n     = 1'b0;
        afe_result = '0;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        repeat (2) @(negedge mclk);
        t_timing();
        t_emitter();
        t_bad_addr();
        t_measure();
        give_verdict();
    end
endmodule : pxr_read_access_bench
